// file: hdl/rss_defs.svh
// timing counts, field positions and reset values for the reset source sequencer
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH

`define RSS_DELAY_TIME_MS 96
`define RSS_RC_FREQ_KHZ 32
`define RSS_DELAY_TICKS (`RSS_DELAY_TIME_MS * `RSS_RC_FREQ_KHZ)
`define RSS_CNT_W 16
`define RSS_CNT_ZERO 16'h0000
`define RSS_CNT_ONE 16'h0001
`define RSS_DOG_RST_CYC 16'h0004
`define RSS_NSYNC 3
`define RSS_SYN_SUPPLY 0
`define RSS_SYN_CLEAR 1
`define RSS_SYN_RC 2
`define RSS_SYNC_RST 1'h0
`define RSS_PHASE_W 4
`define RSS_PHASE_ONE 4'h1
`define RSS_WAKE_W 8

`endif

// file: hdl/rss_pkg.sv
// shared types of the reset source sequencer
package rss_pkg;

    typedef enum logic [5:0] {
        RSS_ST_POR   = 6'h01,
        RSS_ST_DELAY = 6'h02,
        RSS_ST_RUN   = 6'h04,
        RSS_ST_SLEEP = 6'h08,
        RSS_ST_CLEAR = 6'h10,
        RSS_ST_DOG   = 6'h20
    } rss_state_e;

    typedef struct packed {
        logic powerup;
        logic ext_clear;
        logic watchdog;
    } rss_cause_s;

    typedef struct packed {
        logic dog_expired_flag;
        logic sleep_entered_flag;
    } rss_flags_s;

    typedef struct packed {
        logic ale;
        logic oe_n;
        logic wr_n;
    } rss_strobe_s;

endpackage : rss_pkg

// file: hdl/rss_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`include "rss_defs.svh"

module rss_sync (
    input wire logic clk_i, // system clock
    input wire logic rst_i, // async reset, active high
    input wire logic d_i, // raw asynchronous level
    output logic q_o // filtered level
);
    logic s1;
    logic s2;
    logic s3;
    logic next_q;

    // a change is accepted only when stages two and three agree
    always_comb begin
        next_q = (s2 == s3) ? s3 : q_o;
    end

    // stage one feeds stage two only, to keep metastability contained
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1 <= `RSS_SYNC_RST;
            s2 <= `RSS_SYNC_RST;
            s3 <= `RSS_SYNC_RST;
            q_o <= `RSS_SYNC_RST;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
            q_o <= next_q;
        end
    end

endmodule : rss_sync

// file: hdl/rss_top.sv
// reset source sequencer: cause tracking, power-up delay, phase hold, bus park
`timescale 1ns/1ps
`include "rss_defs.svh"

module rss_top
    import rss_pkg::*;
#(
    parameter logic [`RSS_CNT_W-1:0] DELAY_TICKS =
        `RSS_CNT_W'(`RSS_DELAY_TICKS), // power-up delay in RC ticks
    parameter bit ENHANCED = 1'b1 // reset also on falling supply
) (
    input wire logic clk_i, // system clock, 250 MHz
    input wire logic rst_i, // async reset, active high
    input wire logic supply_ok_i, // supply monitor, high above trip
    input wire logic external_clear_n_i, // external clear pin, active low
    input wire logic rc_osc_i, // dedicated RC oscillator square wave
    input wire logic watchdog_timeout_reset_i, // watchdog expiry pulse
    input wire logic sleep_cmd_i, // core executes sleep, pulse
    input wire logic clrwdt_cmd_i, // core clears watchdog, pulse
    input wire logic [`RSS_WAKE_W-1:0] wake_irq_i, // wake interrupt sources
    input wire logic ext_fetch_mode_i, // mode fetches from external memory
    input wire rss_strobe_s core_strobe_i, // strobes from the core
    output logic core_reset_o, // internal reset, active high
    output logic load_defaults_o, // load defined reset values
    output logic immune_undef_o, // immune registers undefined
    output logic wake_o, // resume pulse out of sleep
    output logic sleeping_o, // device in sleep
    output rss_cause_s cause_o, // last reset cause
    output rss_flags_s flags_o, // dog-expired and sleep-entered flags
    output logic [`RSS_PHASE_W-1:0] phase_o, // one-hot phase clock
    output rss_strobe_s strobe_o, // external bus strobes
    output logic strobe_oe_o // strobe pins driven
);

    logic [`RSS_NSYNC-1:0] raw;
    logic [`RSS_NSYNC-1:0] syn;
    logic supply_ok;
    logic clear_ok;
    logic rc_lvl;
    logic rc_prev;
    logic rc_tick;
    rss_state_e state;
    rss_state_e next_state;
    logic [`RSS_CNT_W-1:0] cnt;
    logic [`RSS_CNT_W-1:0] next_cnt;
    rss_cause_s next_cause;
    rss_flags_s next_flags;
    logic next_wake;
    logic in_rst;
    logic next_core_reset;
    logic next_load;
    logic next_immune;
    logic next_sleeping;
    logic [`RSS_PHASE_W-1:0] next_phase;
    rss_strobe_s next_strobe;
    logic next_strobe_oe;

    // every pin level passes the three-stage filter
    assign raw = {rc_osc_i, external_clear_n_i, supply_ok_i};
    generate
        for (genvar g = 0; g < `RSS_NSYNC; g++) begin : g_sync
            rss_sync u_sync (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .d_i(raw[g]),
                .q_o(syn[g])
            );
        end
    endgenerate

    assign supply_ok = syn[`RSS_SYN_SUPPLY];
    assign clear_ok = syn[`RSS_SYN_CLEAR];
    assign rc_lvl = syn[`RSS_SYN_RC];
    // rc edge taken from the filtered level, never from the first stage
    assign rc_tick = rc_lvl & ~rc_prev;

    // sequencer next state, counter, cause and flags
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_cause = cause_o;
        next_flags = flags_o;
        next_wake = 1'b0;
        case (state)
            RSS_ST_POR: begin
                next_cause = '{powerup: 1'b1, ext_clear: 1'b0, watchdog: 1'b0};
                next_flags = '{dog_expired_flag: 1'b1, sleep_entered_flag: 1'b1};
                next_cnt = `RSS_CNT_ZERO;
                if (supply_ok && clear_ok) begin
                    next_state = RSS_ST_DELAY;
                end
            end
            RSS_ST_DELAY: begin
                if (rc_tick) begin
                    if (cnt == DELAY_TICKS - `RSS_CNT_ONE) begin
                        next_state = clear_ok ? RSS_ST_RUN : RSS_ST_CLEAR;
                    end else begin
                        next_cnt = cnt + `RSS_CNT_ONE;
                    end
                end
            end
            RSS_ST_RUN: begin
                if (!clear_ok) begin
                    next_state = RSS_ST_CLEAR;
                    next_cause = '{powerup: 1'b0, ext_clear: 1'b1, watchdog: 1'b0};
                end else if (watchdog_timeout_reset_i) begin
                    next_state = RSS_ST_DOG;
                    next_cnt = `RSS_CNT_ZERO;
                    next_cause = '{powerup: 1'b0, ext_clear: 1'b0, watchdog: 1'b1};
                    next_flags = '{dog_expired_flag: 1'b0, sleep_entered_flag: 1'b1};
                end else if (sleep_cmd_i) begin
                    next_state = RSS_ST_SLEEP;
                    next_flags = '{dog_expired_flag: 1'b1, sleep_entered_flag: 1'b0};
                end else if (clrwdt_cmd_i) begin
                    next_flags = '{dog_expired_flag: 1'b1, sleep_entered_flag: 1'b1};
                end
            end
            RSS_ST_SLEEP: begin
                if (!clear_ok) begin
                    // clear in sleep is a full reset; flags untouched
                    next_state = RSS_ST_CLEAR;
                    next_cause = '{powerup: 1'b0, ext_clear: 1'b1, watchdog: 1'b0};
                end else if (watchdog_timeout_reset_i) begin
                    next_state = RSS_ST_RUN;
                    next_wake = 1'b1;
                    next_flags = '{dog_expired_flag: 1'b0, sleep_entered_flag: 1'b0};
                end else if (|wake_irq_i) begin
                    next_state = RSS_ST_RUN;
                    next_wake = 1'b1;
                end
            end
            RSS_ST_CLEAR: begin
                // released on the clock once the filtered pin is high
                if (clear_ok) begin
                    next_state = RSS_ST_RUN;
                end
            end
            RSS_ST_DOG: begin
                // watchdog reset is a short fixed pulse
                if (cnt == `RSS_DOG_RST_CYC - `RSS_CNT_ONE) begin
                    next_state = RSS_ST_RUN;
                end else begin
                    next_cnt = cnt + `RSS_CNT_ONE;
                end
            end
            default: begin
                next_state = RSS_ST_POR;
                next_cnt = `RSS_CNT_ZERO;
            end
        endcase
        // low supply overrides all; older parts only see it in the POR state, not during the delay
        if (!supply_ok && (ENHANCED || state == RSS_ST_POR)) begin
            next_state = RSS_ST_POR;
            next_cnt = `RSS_CNT_ZERO;
            next_wake = 1'b0;
            next_cause = '{powerup: 1'b1, ext_clear: 1'b0, watchdog: 1'b0};
            next_flags = '{dog_expired_flag: 1'b1, sleep_entered_flag: 1'b1};
        end
    end

    // sequencer registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= RSS_ST_POR;
            cnt <= `RSS_CNT_ZERO;
            cause_o <= '{powerup: 1'b1, ext_clear: 1'b0, watchdog: 1'b0};
            flags_o <= '{dog_expired_flag: 1'b1, sleep_entered_flag: 1'b1};
            wake_o <= 1'b0;
            rc_prev <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            cause_o <= next_cause;
            flags_o <= next_flags;
            wake_o <= next_wake;
            rc_prev <= rc_lvl;
        end
    end

    // outputs derived from the next state so they register with it
    always_comb begin
        in_rst = (next_state == RSS_ST_POR) || (next_state == RSS_ST_DELAY) ||
                 (next_state == RSS_ST_CLEAR) || (next_state == RSS_ST_DOG);
        next_core_reset = in_rst;
        next_load = in_rst;
        next_immune = (next_state == RSS_ST_POR) || (next_state == RSS_ST_DELAY);
        next_sleeping = (next_state == RSS_ST_SLEEP);
        // phase clock stops in sleep, since the oscillator is parked there
        if (in_rst) begin
            next_phase = `RSS_PHASE_ONE;
        end else if (next_state == RSS_ST_RUN) begin
            next_phase = {phase_o[`RSS_PHASE_W-2:0], phase_o[`RSS_PHASE_W-1]};
        end else begin
            next_phase = phase_o;
        end
        // strobes parked only in external fetch modes; otherwise core owns them
        if (in_rst && ext_fetch_mode_i) begin
            next_strobe = '{ale: 1'b0, oe_n: 1'b1, wr_n: 1'b1};
        end else begin
            next_strobe = core_strobe_i;
        end
        next_strobe_oe = ext_fetch_mode_i;
    end

    // output registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            core_reset_o <= 1'b1;
            load_defaults_o <= 1'b1;
            immune_undef_o <= 1'b1;
            sleeping_o <= 1'b0;
            phase_o <= `RSS_PHASE_ONE;
            strobe_o <= '{ale: 1'b0, oe_n: 1'b1, wr_n: 1'b1};
        end else begin
            core_reset_o <= next_core_reset;
            load_defaults_o <= next_load;
            immune_undef_o <= next_immune;
            sleeping_o <= next_sleeping;
            phase_o <= next_phase;
            strobe_o <= next_strobe;
        end
    end

    // no reset here: the pin enable follows the mode right through rst_i,
    // so the parked strobes are really driven from the first edge onward
    always_ff @(posedge clk_i) begin
        strobe_oe_o <= next_strobe_oe;
    end

    // checks on the sequencer behaviour
    phase_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        core_reset_o |-> phase_o == `RSS_PHASE_ONE)
        else $error("phase clock not held at phase one in reset");

    bus_park_a: assert property (@(posedge clk_i) disable iff (rst_i)
        core_reset_o && $past(ext_fetch_mode_i) |->
            strobe_oe_o && !strobe_o.ale && strobe_o.oe_n && strobe_o.wr_n)
        else $error("bus strobes not parked during reset");

    sleep_dog_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state == RSS_ST_SLEEP && watchdog_timeout_reset_i && clear_ok && supply_ok |=>
            !load_defaults_o && wake_o && state == RSS_ST_RUN && !flags_o.dog_expired_flag)
        else $error("watchdog in sleep did not resume cleanly");

    clear_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == RSS_ST_RUN || state == RSS_ST_SLEEP) && !clear_ok && supply_ok |=>
            flags_o == $past(flags_o) && cause_o.ext_clear && load_defaults_o)
        else $error("external clear disturbed status flags");

    dog_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state == RSS_ST_RUN && clear_ok && supply_ok && watchdog_timeout_reset_i |=>
            !flags_o.dog_expired_flag && flags_o.sleep_entered_flag && core_reset_o
            ##1 core_reset_o ##1 core_reset_o ##1 core_reset_o)
        else $error("watchdog reset flags or length wrong");

    supply_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ENHANCED && !supply_ok |=> core_reset_o && immune_undef_o && cause_o.powerup)
        else $error("low supply did not force power-up reset");

    delay_length_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(state) == RSS_ST_DELAY && state != RSS_ST_DELAY && state != RSS_ST_POR |->
            $past(cnt) == DELAY_TICKS - `RSS_CNT_ONE && $past(rc_tick))
        else $error("power-up delay ended early");

    delay_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state == RSS_ST_DELAY |-> core_reset_o && immune_undef_o)
        else $error("reset released during power-up delay");

    release_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(core_reset_o) |-> $past(clear_ok) && $past(supply_ok) && !immune_undef_o)
        else $error("reset released without clean pin levels");

    wake_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state == RSS_ST_SLEEP && (|wake_irq_i) && clear_ok && supply_ok |=>
            wake_o && !sleeping_o && !core_reset_o)
        else $error("interrupt did not wake from sleep");

    immune_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
        immune_undef_o |-> cause_o.powerup && !cause_o.ext_clear && !cause_o.watchdog)
        else $error("immune registers disturbed on non power-up reset");

    // main scenarios
    delay_done_c: cover property (@(posedge clk_i) disable iff (rst_i)
        state == RSS_ST_DELAY ##1 state == RSS_ST_RUN);
    sleep_wake_c: cover property (@(posedge clk_i) disable iff (rst_i)
        state == RSS_ST_SLEEP ##1 wake_o);
    clear_sleep_c: cover property (@(posedge clk_i) disable iff (rst_i)
        state == RSS_ST_SLEEP ##1 state == RSS_ST_CLEAR);
    dog_reset_c: cover property (@(posedge clk_i) disable iff (rst_i)
        state == RSS_ST_RUN ##1 state == RSS_ST_DOG);

endmodule : rss_top

// file: verif/rss_pin_model.sv
// supply monitor, external clear pin and free-running rc oscillator
`timescale 1ns/1ps

module rss_pin_model (
    input wire logic supply_en_i, // bench asks for supply above trip
    input wire logic clear_en_i, // bench releases the clear pin
    output logic supply_ok_o, // supply monitor level
    output logic external_clear_n_o, // clear pin, active low
    output logic rc_osc_o // rc square wave
);
    // pins move a little after the request, never aligned to the system clock
    always @(supply_en_i) supply_ok_o <= #3.3 supply_en_i;
    always @(clear_en_i) external_clear_n_o <= #2.7 clear_en_i;

    // rc runs free, unrelated to clk_i, so the delay timer sees a foreign clock
    initial begin
        rc_osc_o = 1'b0;
        supply_ok_o = 1'b1;
        external_clear_n_o = 1'b1;
    end
    always #26.1 rc_osc_o = ~rc_osc_o;
endmodule : rss_pin_model

// file: verif/test_reset_source_sequencer.sv
// self-checking bench for the reset source sequencer
`timescale 1ns/1ps
`include "rss_defs.svh"

module test_reset_source_sequencer;
    import rss_pkg::*;

    typedef struct packed {
        logic wake;
        rss_cause_s cause;
        rss_flags_s flags;
    } rss_note_s;

    logic clk_i = 1'b0, rst_i = 1'b1, supply_en = 1'b1, clear_en = 1'b1;
    logic supply_ok, clear_n, rc_osc, wd = 1'b0, sleep_cmd = 1'b0, clrwdt = 1'b0;
    logic ext_mode = 1'b1, core_reset, load_def, immune, wake, sleeping, strobe_oe;
    logic [7:0] wake_irq = 8'h00;
    logic [3:0] phase;
    logic [31:0] seed = 32'h00000024;
    rss_strobe_s core_strobe = 3'h3, strobe;
    rss_cause_s cause;
    rss_flags_s flags;
    rss_note_s notes[$];
    int errors = 0, compares = 0;

    always #2 clk_i = ~clk_i;

    rss_pin_model pins_u (.supply_en_i(supply_en), .clear_en_i(clear_en),
        .supply_ok_o(supply_ok), .external_clear_n_o(clear_n), .rc_osc_o(rc_osc));

    rss_top #(.DELAY_TICKS(16'h0004), .ENHANCED(1'b1)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .supply_ok_i(supply_ok), .external_clear_n_i(clear_n), .rc_osc_i(rc_osc),
        .watchdog_timeout_reset_i(wd), .sleep_cmd_i(sleep_cmd), .clrwdt_cmd_i(clrwdt),
        .wake_irq_i(wake_irq), .ext_fetch_mode_i(ext_mode), .core_strobe_i(core_strobe),
        .core_reset_o(core_reset), .load_defaults_o(load_def), .immune_undef_o(immune),
        .wake_o(wake), .sleeping_o(sleeping), .cause_o(cause), .flags_o(flags),
        .phase_o(phase), .strobe_o(strobe), .strobe_oe_o(strobe_oe));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic summarize();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize

    // one-cycle command pulse launched on a falling edge
    task automatic pulse(ref logic sig);
        @(negedge clk_i) sig = 1'b1;
        @(negedge clk_i) sig = 1'b0;
    endtask : pulse

    task automatic wait_level(ref logic sig, input logic lvl);
        int n;
        for (n = 0; n < 3000 && sig !== lvl; n++) @(posedge clk_i);
        if (sig !== lvl) chk("wait_level", 8'h00, 8'h01);
        @(negedge clk_i);
    endtask : wait_level

    // running checks: phase rotates, strobes follow the core
    task automatic run_check();
        logic [3:0] p1;
        seed = xorshift(seed);
        @(negedge clk_i) core_strobe = seed[2:0];
        repeat (3) @(negedge clk_i);
        chk("strobe_pass", 8'(strobe), 8'(core_strobe));
        p1 = phase;
        @(negedge clk_i);
        chk("phase_rot", 8'(phase), 8'({p1[2:0], p1[3]}));
        chk("immune_run", 8'(immune), 8'h00);
    endtask : run_check

    task automatic note(input logic w, input rss_cause_s c, input rss_flags_s f);
        notes.push_back({w, c, f});
    endtask : note

    // monitor: each reset entry or wake pulse consumes the oldest note
    always @(posedge clk_i) begin
        logic was_rst;
        rss_note_s n;
        was_rst = core_reset;
        #1;
        if (!rst_i && (wake === 1'b1 || (core_reset === 1'b1 && was_rst === 1'b0))) begin
            if (notes.size() == 0) begin
                chk("unexpected_event", 8'h01, 8'h00);
            end else begin
                n = notes.pop_front();
                chk("wake", 8'(wake), 8'(n.wake));
                chk("load_defaults", 8'(load_def), 8'(!n.wake));
                chk("flags", 8'(flags), 8'(n.flags));
                chk("sleeping", 8'(sleeping), 8'h00);
                if (!n.wake) begin
                    chk("cause", 8'(cause), 8'(n.cause));
                    chk("phase_hold", 8'(phase), 8'(`RSS_PHASE_ONE));
                    chk("strobe_park", 8'(strobe), ext_mode ? 8'h03 : 8'(core_strobe));
                    chk("immune", 8'(immune), 8'(n.cause.powerup));
                end
            end
        end
    end

    initial begin
        #200000;
        chk("watchdog_timer", 8'h00, 8'h01);
        summarize();
    end

    initial begin
        repeat (16) @(negedge clk_i);
        chk("rst_phase", 8'(phase), 8'(`RSS_PHASE_ONE));
        chk("rst_strobe", 8'(strobe), 8'h3);
        chk("rst_immune", 8'(immune), 8'h01);
        rst_i = 1'b0;
        repeat (30) @(negedge clk_i);
        chk("delay_hold", 8'(core_reset), 8'h01);
        wait_level(core_reset, 1'b0);
        run_check();
        // watchdog while running, then a watchdog clear brings both flags back
        note(1'b0, 3'b001, 2'b01);
        pulse(wd);
        wait_level(core_reset, 1'b0);
        run_check();
        pulse(clrwdt);
        @(negedge clk_i);
        chk("flags_clrwdt", 8'(flags), 8'h3);
        // sleep then interrupt wake, random source bit
        pulse(sleep_cmd);
        chk("sleep_flags", 8'(flags), 8'h2);
        chk("sleeping_on", 8'(sleeping), 8'h01);
        seed = xorshift(seed);
        note(1'b1, 3'b001, 2'b10);
        @(negedge clk_i) wake_irq = 8'h01 << seed[2:0];
        @(negedge clk_i) wake_irq = 8'h00;
        run_check();
        // watchdog during sleep resumes without defaults
        pulse(sleep_cmd);
        note(1'b1, 3'b001, 2'b00);
        pulse(wd);
        run_check();
        // clear pin in run keeps flags
        note(1'b0, 3'b010, 2'b00);
        @(negedge clk_i) clear_en = 1'b0;
        wait_level(core_reset, 1'b1);
        clear_en = 1'b1;
        wait_level(core_reset, 1'b0);
        run_check();
        // clear pin during sleep, in a mode without external fetch: no park
        pulse(sleep_cmd);
        note(1'b0, 3'b010, 2'b10);
        ext_mode = 1'b0;
        clear_en = 1'b0;
        wait_level(core_reset, 1'b1);
        chk("strobe_oe_off", 8'(strobe_oe), 8'h00);
        clear_en = 1'b1;
        wait_level(core_reset, 1'b0);
        ext_mode = 1'b1;
        // supply dips below trip while running
        note(1'b0, 3'b100, 2'b11);
        supply_en = 1'b0;
        wait_level(core_reset, 1'b1);
        supply_en = 1'b1;
        wait_level(core_reset, 1'b0);
        chk("strobe_oe", 8'(strobe_oe), 8'h01);
        run_check();
        chk("notes_left", 8'(notes.size()), 8'h00);
        summarize();
    end
endmodule : test_reset_source_sequencer
